// File: pkg/lir_consts.svh
`ifndef LIR_CONSTS_SVH
`define LIR_CONSTS_SVH
// ****************
// Register indices; the byte address is four times the index.
// ****************
`define LIR_IDX_STAT      3'h0
`define LIR_IDX_FLAG      3'h1
`define LIR_IDX_DATA      3'h2
`define LIR_IDX_POLL      3'h3
`define LIR_IDX_ADDR      3'h4
`define LIR_IDX_SCRA      3'h5
`define LIR_IDX_SCRB      3'h6
`define LIR_IDX_AUX       3'h7
// ****************
// Status register fields (own offset 0x0).
// ****************
`define LIR_ST_SC         7
`define LIR_ST_CA         6
`define LIR_ST_TA         5
`define LIR_ST_LA         4
`define LIR_ST_LOCAL_READY_STROBE      2
`define LIR_ST_CLR        1
`define LIR_ST_MCL        0
// ****************
// Flag register read fields; enables in write bits 7:3.
// ****************
`define LIR_FL_EN_LSB     3
`define LIR_FL_CIN_LSB    0
// ****************
// Poll register fields.
// ****************
`define LIR_PP_ORE        7
`define LIR_PP_RECEIVER_SYNC_FAULT       6
`define LIR_PP_EN         5
`define LIR_PP_LVL        4
`define LIR_PP_POL        3
// ****************
// Frame times.
// ****************
`define LIR_FRAME_NS      46000
`define LIR_CLK_NS        5
`define LIR_FRAME_CYC     (`LIR_FRAME_NS / `LIR_CLK_NS)
`endif

// File: pkg/lir_pkg.sv
package lir_pkg;
    // Frame class as reported by the receiver front end.
    typedef enum logic [2:0] {
        LIR_DOE = 3'b000,
        LIR_CMD = 3'b001,
        LIR_IFC = 3'b010,
        LIR_RFC = 3'b011,
        LIR_ARG = 3'b100,
        LIR_AAG = 3'b101,
        LIR_IDY = 3'b110,
        LIR_OTH = 3'b111
    } lir_kind_t;
    typedef enum logic [1:0] {
        LIR_TX_IDLE = 2'b00,
        LIR_TX_AUTO = 2'b01,
        LIR_TX_HOST = 2'b10
    } lir_tx_t;
endpackage : lir_pkg

// File: logic/lir_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "lir_consts.svh"
// Contract
// R1: Received control bits latch with available or mismatch flag, held until data read.
// R2: Data read clearing a flag copies received control bits into transmit control.
// R3: Data write loads output register and starts transmit, waiting out retransmission.
// R4: Every received clear command sets its flag; cleared by strobe or master clear.
// R5: Local ready ignored while clear flag set; combined write with clear strobe works.
// R6: Service request flag follows C0 of DOE/IDY while controller active, else zero.
// R7: Frame available set on listener DOE, active ARG, inactive AAG/commands, analyzer.
// R8: Frame available cleared by data read or master clear.
// R9: Mismatch loads frame and sets mismatch flag; never both flags together.
// R10: Check CMD/AAG/IDY as controller, DOE as talker, never in analyzer mode.
// R11: Mismatch flag cleared by data read or master clear.
// R12: Output free set on the listed handshake completions, errors, idle roles, clear.
// R13: Data write clears output free unless idle roles or master clear.
// R14: Interrupt line low while any enabled flag is set.
// R15: No new frame loads while an available or mismatch flag is pending.
// R16: Output empty cleared by data write, set after eleven-bit frame completes.
// R17: Sync fault set on mid-frame sync, cleared by poll register write.
// R18: Poll enable sets selected IDY bit when level matches polarity.
// R19: Low five address bits match talk/listen; address 31 matches un-commands.
// R20: Aux register reads two live inputs on top, ones elsewhere.
// R21: Oscillator off only under master clear; restarts on bit clear or any read.
// R22: Host reads received control bits before reading the data register.
// R23: Master clear clears flags and enables, sets output free and empty, clears latch.
// R24: Analyzer mode loads every frame as available, no retransmit or checking.
// R25: Scratch registers store and return written values without side effects.
module lir_regs #(
    parameter int FRAME_CYC = `LIR_FRAME_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        rx_valid_i,
    input  wire logic [2:0]  rx_ctrl_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic [2:0]  rx_kind_i,
    input  wire logic        rx_sync_fault_i,
    input  wire logic [1:0]  aux_in_i,
    output logic             tx_valid_o,
    output logic      [2:0]  tx_ctrl_o,
    output logic      [7:0]  tx_data_o,
    output logic             tx_auto_o,
    output logic             irq_n_o,
    output logic             osc_run_o,
    output logic             local_ready_o,
    output logic             rfc_source_o
);
    if (FRAME_CYC < 1) begin : g_bad_frame_cyc
        $error("FRAME_CYC must be at least one");
    end
    // ****************
    // Pin synchronisers.
    // ****************
    logic [1:0] aux_s1;
    logic [1:0] aux_s2;
    // Auxiliary pins are asynchronous, so they pass two flops first.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            aux_s1 <= 2'h3;
            aux_s2 <= 2'h3;
        end else if (clk_en_i) begin
            aux_s1 <= aux_in_i;
            aux_s2 <= aux_s1;
        end
    end
    // ****************
    // Bus slave.
    // ****************
    logic       ph_wr;
    logic       ph_rd;
    logic [2:0] ph_idx;
    // Address phase is captured; zero-wait data phase follows.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ph_wr  <= 1'b0;
            ph_rd  <= 1'b0;
            ph_idx <= 3'h0;
        end else if (clk_en_i && hready_i) begin
            ph_wr  <= hsel_i && htrans_i[1] && hwrite_i;
            ph_rd  <= hsel_i && htrans_i[1] && !hwrite_i;
            ph_idx <= haddr_i[4:2];
        end
    end
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    wire logic  wr_st  = clk_en_i && ph_wr && ph_idx == `LIR_IDX_STAT;
    wire logic  wr_fl  = clk_en_i && ph_wr && ph_idx == `LIR_IDX_FLAG;
    wire logic  wr_dt  = clk_en_i && ph_wr && ph_idx == `LIR_IDX_DATA;
    wire logic  wr_pp  = clk_en_i && ph_wr && ph_idx == `LIR_IDX_POLL;
    wire logic  rd_dt  = clk_en_i && ph_rd && ph_idx == `LIR_IDX_DATA;
    wire logic  rd_any = clk_en_i && ph_rd;
    // ****************
    // Software registers.
    // ****************
    logic [7:0] stat;
    logic [4:0] irq_en;
    logic [5:0] poll;
    logic [7:0] loop_addr;
    logic [7:0] scr_a;
    logic [7:0] scr_b;
    logic       osc_off;
    wire logic  master_clear      = stat[`LIR_ST_MCL];
    wire logic  ca       = stat[`LIR_ST_CA];
    wire logic  ta       = stat[`LIR_ST_TA];
    wire logic  la       = stat[`LIR_ST_LA];
    wire logic  sc       = stat[`LIR_ST_SC];
    wire logic  analyzer = ta && la; // [R24]
    // Status bits; strobes are not stored. Reset enters master clear.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stat <= 8'h01;
        end else if (wr_st) begin
            stat <= {hwdata_i[7:4], 3'h0, hwdata_i[`LIR_ST_MCL]};
        end
    end
    // Enables are cleared while master clear stands.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && master_clear)) begin
            irq_en <= 5'h00; // [R23]
        end else if (wr_fl) begin
            irq_en <= hwdata_i[7:3];
        end
    end
    // Poll, address and scratch storage change only on writes.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            poll      <= 6'h00;
            loop_addr <= 8'h00;
            scr_a     <= 8'h00;
            scr_b     <= 8'h00;
            osc_off   <= 1'b0;
        end else if (clk_en_i && ph_wr) begin
            if (ph_idx == `LIR_IDX_POLL) poll <= hwdata_i[5:0];
            if (ph_idx == `LIR_IDX_ADDR) loop_addr <= hwdata_i[7:0]; // [R19]
            if (ph_idx == `LIR_IDX_SCRA) scr_a <= hwdata_i[7:0]; // [R25]
            if (ph_idx == `LIR_IDX_SCRB) scr_b <= hwdata_i[7:0]; // [R25]
            if (ph_idx == `LIR_IDX_AUX) osc_off <= hwdata_i[0];
        end else if (rd_any) begin
            osc_off <= 1'b0; // [R21]
        end
    end
    // The oscillator only stops while master clear holds the part idle.
    assign osc_run_o = !(osc_off && master_clear); // [R21]
    // ****************
    // Frame decode.
    // ****************
    lir_pkg::lir_kind_t kind;
    logic addr_hit;
    logic device_relevant_commands;
    logic do_chk;
    logic mism;
    logic do_load;
    logic do_auto;
    logic [7:0] out_data;
    logic [2:0] out_ctrl;
    logic       pend;
    logic       srq_last;
    assign kind = lir_pkg::lir_kind_t'(rx_kind_i);
    // Talk/listen address groups carry the address in data bits 4:0.
    assign addr_hit = rx_data_i[4:0] == loop_addr[4:0]; // [R19]
    assign device_relevant_commands = !ca && kind == lir_pkg::LIR_CMD &&
                  (ta || la || rx_data_i[7:6] != 2'b00 || rx_data_i[5] == 1'b0 ?
                   1'b1 : addr_hit);
    // SRQ bit is excluded from the compare of DOE and IDY frames.
    assign do_chk = !analyzer && // [R10]
                    ((ca && (kind == lir_pkg::LIR_CMD || kind == lir_pkg::LIR_AAG ||
                             kind == lir_pkg::LIR_IDY || (kind == lir_pkg::LIR_IFC && sc)))
                     || (ta && kind == lir_pkg::LIR_DOE));
    assign mism = do_chk && ({rx_ctrl_i[2:1], rx_data_i} != {out_ctrl[2:1], out_data} ||
                  (kind != lir_pkg::LIR_DOE && kind != lir_pkg::LIR_IDY &&
                   rx_ctrl_i[0] != out_ctrl[0]));
    assign do_load = analyzer || // [R7]
                     (la && kind == lir_pkg::LIR_DOE) ||
                     ((ca || ta || la) && kind == lir_pkg::LIR_ARG) ||
                     (!ca && (kind == lir_pkg::LIR_AAG || device_relevant_commands));
    assign do_auto = !analyzer &&
                     ((!ca && !ta && !la && kind == lir_pkg::LIR_ARG) ||
                      (!ca && (kind == lir_pkg::LIR_CMD || kind == lir_pkg::LIR_RFC ||
                               kind == lir_pkg::LIR_IDY || kind == lir_pkg::LIR_IFC)) ||
                      (!ta && !la && kind == lir_pkg::LIR_DOE));
    assign rfc_source_o = rx_valid_i && clk_en_i && do_chk && !mism &&
                          kind != lir_pkg::LIR_DOE && kind != lir_pkg::LIR_IDY &&
                          kind != lir_pkg::LIR_AAG;
    // ****************
    // Receive flags and held frame.
    // ****************
    logic       fav;
    logic       fns;
    logic       ofree;
    logic       ifc_seen;
    logic       srq_seen;
    logic [2:0] rx_ctrl_hold;
    logic [7:0] rx_data_hold;
    logic       take;
    logic       clr_strobe;
    assign pend = fav || fns;
    assign take = clk_en_i && rx_valid_i && !pend && (mism || do_load); // [R15]
    assign clr_strobe = wr_st && hwdata_i[`LIR_ST_CLR];
    // Received frame capture; new frames are held off while one is pending.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_ctrl_hold <= 3'h0;
            rx_data_hold <= 8'h00;
        end else if (take) begin
            rx_ctrl_hold <= rx_ctrl_i; // [R1]
            rx_data_hold <= rx_data_i; // [R9]
        end
    end
    // A new frame cannot land while a flag is set, so a read's clear never races it.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && master_clear)) begin
            fav <= 1'b0; // [R8]
            fns <= 1'b0; // [R11]
        end else if (take) begin
            fav <= !mism; // [R7]
            fns <= mism;  // [R9]
        end else if (rd_dt) begin
            fav <= 1'b0; // [R8]
            fns <= 1'b0; // [R11]
        end
    end
    // Set wins over the strobe so a clear command in the same cycle is kept.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && master_clear)) begin
            ifc_seen <= 1'b0; // [R23]
        end else if (clk_en_i && rx_valid_i && kind == lir_pkg::LIR_IFC) begin
            ifc_seen <= 1'b1; // [R4]
        end else if (clr_strobe) begin
            ifc_seen <= 1'b0; // [R4]
        end
    end
    // Local ready acts when the clear flag is free or cleared in the same write.
    assign local_ready_o = wr_st && hwdata_i[`LIR_ST_LOCAL_READY_STROBE] &&
                           (!ifc_seen || hwdata_i[`LIR_ST_CLR]); // [R5]
    // Service request tracks C0 only as controller.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && (master_clear || !ca))) begin
            srq_seen <= 1'b0; // [R6]
        end else if (clk_en_i && rx_valid_i &&
                     (kind == lir_pkg::LIR_DOE || kind == lir_pkg::LIR_IDY)) begin
            srq_seen <= rx_ctrl_i[0]; // [R6]
        end
    end
    // Last SRQ seen as non-controller, merged into retransmitted DOE and IDY frames.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && master_clear)) begin
            srq_last <= 1'b0; // [R23]
        end else if (clk_en_i && rx_valid_i && !ca &&
                     (kind == lir_pkg::LIR_DOE || kind == lir_pkg::LIR_IDY)) begin
            srq_last <= rx_ctrl_i[0];
        end
    end
    // Handshake completion sets the flag; set outranks a data write.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && (master_clear || (!ca && !ta)))) begin
            ofree <= 1'b1; // [R12]
        end else if (clk_en_i && rx_valid_i && !analyzer &&
                     ((kind == lir_pkg::LIR_DOE && (ta || (ca && la))) ||
                      (kind == lir_pkg::LIR_IFC && ca && !sc) ||
                      (ca && (kind == lir_pkg::LIR_RFC || kind == lir_pkg::LIR_AAG ||
                              kind == lir_pkg::LIR_IDY)) ||
                      (kind == lir_pkg::LIR_ARG && (ca || ta || la)) || mism)) begin
            ofree <= 1'b1; // [R12]
        end else if (wr_dt) begin
            ofree <= 1'b0; // [R13]
        end
    end
    // ****************
    // Transmit path.
    // ****************
    logic [2:0] tx_ctrl_w;
    logic       host_req;
    logic       output_empty_flag;
    logic       receiver_sync_fault;
    logic [7:0] idy_mod;
    lir_pkg::lir_tx_t tx_st;
    logic [$clog2(FRAME_CYC+1)-1:0] tx_cnt;
    // Control bits follow software writes and reloads from the held frame.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tx_ctrl_w <= 3'h0;
        end else if (rd_dt && pend) begin
            tx_ctrl_w <= rx_ctrl_hold; // [R2]
        end else if (wr_fl) begin
            tx_ctrl_w <= hwdata_i[2:0];
        end
    end
    // Parallel poll response merged into passing IDY frames.
    always_comb begin
        idy_mod = rx_data_i;
        if (poll[`LIR_PP_EN] && poll[`LIR_PP_LVL] == poll[`LIR_PP_POL]) begin
            idy_mod[poll[2:0]] = 1'b1; // [R18]
        end
    end
    // Frame timer: each start holds the transmitter one frame time.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tx_st     <= lir_pkg::LIR_TX_IDLE;
            tx_cnt    <= '0;
            host_req  <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_auto_o <= 1'b0;
            tx_ctrl_o <= 3'h0;
            tx_data_o <= 8'h00;
            out_ctrl  <= 3'h0;
            out_data  <= 8'h00;
        end else if (clk_en_i) begin
            tx_valid_o <= 1'b0;
            if (wr_dt) begin
                out_ctrl <= tx_ctrl_w; // [R3]
                out_data <= hwdata_i[7:0];
                host_req <= 1'b1;
            end
            unique case (tx_st)
                lir_pkg::LIR_TX_IDLE: begin
                    if (rx_valid_i && do_auto) begin
                        tx_st      <= lir_pkg::LIR_TX_AUTO;
                        tx_cnt     <= FRAME_CYC[$bits(tx_cnt)-1:0];
                        tx_valid_o <= 1'b1;
                        tx_auto_o  <= 1'b1;
                        tx_ctrl_o  <= {rx_ctrl_i[2:1], rx_ctrl_i[0] | (srq_last && !ca &&
                                       (kind == lir_pkg::LIR_DOE || kind == lir_pkg::LIR_IDY))};
                        tx_data_o  <= (kind == lir_pkg::LIR_IDY) ? idy_mod : rx_data_i;
                    end else if (host_req) begin
                        tx_st      <= lir_pkg::LIR_TX_HOST; // [R3]
                        tx_cnt     <= FRAME_CYC[$bits(tx_cnt)-1:0];
                        host_req   <= wr_dt;
                        tx_valid_o <= 1'b1;
                        tx_auto_o  <= 1'b0;
                        tx_ctrl_o  <= out_ctrl;
                        tx_data_o  <= out_data;
                    end
                end
                lir_pkg::LIR_TX_AUTO, lir_pkg::LIR_TX_HOST: begin
                    if (tx_cnt == 1) begin
                        tx_st <= lir_pkg::LIR_TX_IDLE;
                    end
                    tx_cnt <= tx_cnt - 1'b1;
                end
                default: tx_st <= lir_pkg::LIR_TX_IDLE;
            endcase
        end
    end
    // Empty flag: cleared on write, set when the host frame has gone out.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || (clk_en_i && master_clear)) begin
            output_empty_flag <= 1'b1; // [R23]
        end else if (wr_dt) begin
            output_empty_flag <= 1'b0; // [R16]
        end else if (clk_en_i && tx_st == lir_pkg::LIR_TX_HOST && tx_cnt == 1 && !host_req) begin
            output_empty_flag <= 1'b1; // [R16]
        end
    end
    // Sync fault: set wins over the clearing write.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            receiver_sync_fault <= 1'b0;
        end else if (clk_en_i && rx_sync_fault_i) begin
            receiver_sync_fault <= 1'b1; // [R17]
        end else if (wr_pp) begin
            receiver_sync_fault <= 1'b0; // [R17]
        end
    end
    // ****************
    // Interrupt and read data.
    // ****************
    logic [4:0] flags;
    assign flags = {ifc_seen, srq_seen, fav, fns, ofree};
    assign irq_n_o = !(|(flags & irq_en)); // [R14]
    // Read data register loads in the address phase, ready for the data phase.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (clk_en_i && hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            unique case (haddr_i[4:2])
                `LIR_IDX_STAT: hrdata_o <= {24'h0, stat};
                `LIR_IDX_FLAG: hrdata_o <= {24'h0, flags, rx_ctrl_hold}; // [R22]
                `LIR_IDX_DATA: hrdata_o <= {24'h0, rx_data_hold};
                `LIR_IDX_POLL: hrdata_o <= {24'h0, output_empty_flag, receiver_sync_fault, poll};
                `LIR_IDX_ADDR: hrdata_o <= {24'h0, loop_addr};
                `LIR_IDX_SCRA: hrdata_o <= {24'h0, scr_a};
                `LIR_IDX_SCRB: hrdata_o <= {24'h0, scr_b};
                `LIR_IDX_AUX:  hrdata_o <= {24'h0, aux_s2, 6'h3f}; // [R20]
            endcase
        end
    end
endmodule : lir_regs
`default_nettype wire

// File: dv/lir_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "lir_consts.svh"
// ****************
// Port checks of the register bank.
// ****************
module lir_regs_properties (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        rx_valid_i,
    input wire logic        tx_valid_o,
    input wire logic        tx_auto_o,
    input wire logic        irq_n_o,
    input wire logic        osc_run_o,
    input wire logic        local_ready_o
);
    localparam int TX_WAIT = 64;
    logic       acc;
    logic [3:0] since_evt;
    // An accepted address phase.
    assign acc = hsel_i && htrans_i[1] && hready_i;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Age of the last bus access or frame; it saturates so a long idle never looks fresh.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || acc || rx_valid_i) since_evt <= '0;
        else if (since_evt != 4'hf) since_evt <= since_evt + 4'h1;
    end
    bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("Bus answer not OKAY.");
    tx_pulse_a: assert property (tx_valid_o |=> !tx_valid_o [*8])
        else $error("Transmit starts too close.");
    tx_start_a: assert property (acc && hwrite_i && haddr_i[4:2] == `LIR_IDX_DATA
        |-> ##[1:TX_WAIT] tx_valid_o) else $error("Data write sent nothing.");
    ready_pulse_a: assert property (local_ready_o |=> !local_ready_o)
        else $error("Local ready longer than a cycle.");
    ready_cause_a: assert property (local_ready_o |-> since_evt <= 4'h3)
        else $error("Local ready without a write.");
    reset_irq_a: assert property ($fell(sys_rst_i) |-> irq_n_o)
        else $error("Interrupt low after clear.");
    osc_read_a: assert property (acc && !hwrite_i |-> ##[1:2] osc_run_o)
        else $error("Read did not start the oscillator.");
    irq_cause_a: assert property ($changed(irq_n_o) |-> since_evt <= 4'h3)
        else $error("Interrupt moved without a cause.");
    cover property (!irq_n_o);
    cover property (local_ready_o);
    cover property (tx_valid_o && tx_auto_o);
endmodule : lir_regs_properties
`default_nettype wire

// File: dv/lir_loop_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// Loop side: hands frames in, catches frames sent out.
// ****************
module lir_loop_model (
    input  wire logic       clock_i,
    input  wire logic       tx_valid_i,
    input  wire logic [2:0] tx_ctrl_i,
    input  wire logic [7:0] tx_data_i,
    output logic            rx_valid_o,
    output logic      [2:0] rx_ctrl_o,
    output logic      [7:0] rx_data_o,
    output logic      [2:0] rx_kind_o,
    output logic            sync_fault_o
);
    logic [10:0] last_tx;
    // A frame stands one cycle; then the lines show its inverse.
    task automatic send(input logic [2:0] k, input logic [2:0] c, input logic [7:0] d);
        @(posedge clock_i);
        {rx_valid_o, rx_kind_o, rx_ctrl_o, rx_data_o} <= {1'b1, k, c, d};
        @(posedge clock_i);
        {rx_valid_o, rx_kind_o, rx_ctrl_o, rx_data_o} <= {1'b0, ~k, ~c, ~d};
    endtask : send
    // A sync bit seen in mid-frame.
    task automatic fault();
        @(posedge clock_i);
        sync_fault_o <= 1'b1;
        @(posedge clock_i);
        sync_fault_o <= 1'b0;
    endtask : fault
    initial {rx_valid_o, rx_kind_o, rx_ctrl_o, rx_data_o, sync_fault_o} = '0;
    // Keep the last frame the block put on the loop.
    always_ff @(posedge clock_i) if (tx_valid_i) last_tx <= {tx_ctrl_i, tx_data_i};
endmodule : lir_loop_model
`default_nettype wire

// File: dv/test_loop_interface_host_registers.sv
`timescale 1ns/10ps
`default_nettype none
`include "lir_consts.svh"
// ****************
// Directed bench for the register bank.
// ****************
module test_loop_interface_host_registers;
    localparam int FC = 20;
    logic        clock_i, sys_rst_i, hsel_i, hwrite_i, rx_valid_i, sync_i, hreadyout_o, hresp_o;
    logic        tx_valid_o, tx_auto_o, irq_n_o, osc_run_o, local_ready_o;
    logic [1:0]  htrans_i, aux_in_i;
    logic [2:0]  rx_ctrl_i, rx_kind_i, tx_ctrl_o;
    logic [7:0]  rx_data_i, tx_data_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    int          num_errors, checked, ready_seen, n0;
    lir_regs #(.FRAME_CYC(FC)) uut (.clock_i, .sys_rst_i, .clk_en_i(1'b1), .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .rx_valid_i, .rx_ctrl_i, .rx_data_i, .rx_kind_i,
        .rx_sync_fault_i(sync_i), .aux_in_i, .tx_valid_o, .tx_ctrl_o, .tx_data_o, .tx_auto_o,
        .irq_n_o, .osc_run_o, .local_ready_o, .rfc_source_o());
    lir_loop_model loop (.clock_i, .tx_valid_i(tx_valid_o), .tx_ctrl_i(tx_ctrl_o),
        .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i), .rx_ctrl_o(rx_ctrl_i),
        .rx_data_o(rx_data_i), .rx_kind_o(rx_kind_i), .sync_fault_o(sync_i));
    // Free-running 5 ns clock.
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // Count local-ready pulses.
    always @(posedge clock_i) if (local_ready_o === 1'b1) ready_seen++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("Checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    // Bounded wait for hready; a hang ends the run as a failure.
    task automatic wait_rdy();
        for (int n = 0; n < 50; n++) begin
            @(posedge clock_i);
            if (hreadyout_o === 1'b1) return;
        end
        num_errors++;
        test_done();
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [2:0] i, input logic [7:0] d);
        @(posedge clock_i);
        {hsel_i, htrans_i, hwrite_i, haddr_i} <= {1'b1, 2'b10, w, 27'h0, i, 2'b00};
        wait_rdy();
        {htrans_i, hwdata_i} <= {2'b00, 24'h00_0000, d};
        wait_rdy();
        rd = hrdata_o;
        #1;
    endtask : xfer
    task automatic rdm(input logic [2:0] i, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, i, 8'h0);
        check(rd & {24'h00_0000, m}, {24'h00_0000, e});
    endtask : rdm
    // Host reads control bits, then data, then resends.
    task automatic t_frame();
        xfer(1'b1, `LIR_IDX_STAT, 8'h10);
        xfer(1'b1, `LIR_IDX_FLAG, 8'h20);
        loop.send(lir_pkg::LIR_DOE, 3'h5, 8'h3C);
        repeat (2) @(posedge clock_i);
        check({31'h0, irq_n_o}, 32'h0);
        loop.send(lir_pkg::LIR_DOE, 3'h3, 8'h77);
        rdm(`LIR_IDX_FLAG, 8'hF7, 8'h25);
        xfer(1'b1, `LIR_IDX_FLAG, 8'h00);
        check({31'h0, irq_n_o}, 32'h1);
        rdm(`LIR_IDX_DATA, 8'hFF, 8'h3C);
        xfer(1'b1, `LIR_IDX_DATA, 8'h3C);
        rdm(`LIR_IDX_POLL, 8'h80, 8'h00);
        repeat (FC + 10) @(posedge clock_i);
        check({21'h0, loop.last_tx}, {21'h0, 3'h5, 8'h3C});
        rdm(`LIR_IDX_POLL, 8'h80, 8'h80);
        $display("t_frame done");
    endtask : t_frame
    // Clear command, local-ready strobe, sync fault and poll response on a passing IDY.
    task automatic t_misc();
        loop.send(lir_pkg::LIR_IFC, 3'h4, 8'h90);
        rdm(`LIR_IDX_FLAG, 8'h80, 8'h80);
        n0 = ready_seen;
        xfer(1'b1, `LIR_IDX_STAT, 8'h14);
        repeat (3) @(posedge clock_i);
        check(ready_seen - n0, 32'h0);
        xfer(1'b1, `LIR_IDX_STAT, 8'h16);
        repeat (3) @(posedge clock_i);
        check(ready_seen - n0, 32'h1);
        rdm(`LIR_IDX_FLAG, 8'h80, 8'h00);
        loop.fault();
        rdm(`LIR_IDX_POLL, 8'h40, 8'h40);
        xfer(1'b1, `LIR_IDX_POLL, 8'h3B);
        rdm(`LIR_IDX_POLL, 8'h7F, 8'h3B);
        loop.send(lir_pkg::LIR_IDY, 3'h6, 8'h00);
        repeat (FC + 10) @(posedge clock_i);
        check({24'h00_0000, loop.last_tx[7:0]}, 32'h8);
        $display("t_misc done");
    endtask : t_misc
    // Reset state, oscillator gate, storage and auxiliary inputs.
    initial begin
        {sys_rst_i, aux_in_i} = 3'h7;
        {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        xfer(1'b1, `LIR_IDX_AUX, 8'h01);
        check({31'h0, osc_run_o}, 32'h0);
        rdm(`LIR_IDX_FLAG, 8'hF8, 8'h08);
        rdm(`LIR_IDX_POLL, 8'h80, 8'h80);
        xfer(1'b1, `LIR_IDX_STAT, 8'h00);
        rdm(`LIR_IDX_FLAG, 8'h08, 8'h08);
        xfer(1'b1, `LIR_IDX_SCRA, 8'hA5);
        xfer(1'b1, `LIR_IDX_ADDR, 8'hFF);
        rdm(`LIR_IDX_SCRA, 8'hFF, 8'hA5);
        rdm(`LIR_IDX_ADDR, 8'hFF, 8'hFF);
        aux_in_i <= 2'b00;
        repeat (3) @(posedge clock_i);
        rdm(`LIR_IDX_AUX, 8'hFF, 8'h3F);
        $display("t_store done");
        t_frame();
        t_misc();
        test_done();
    end
endmodule : test_loop_interface_host_registers
bind lir_regs lir_regs_properties u_props (.clock_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hready_i, .hreadyout_o, .hresp_o, .rx_valid_i, .tx_valid_o, .tx_auto_o,
    .irq_n_o, .osc_run_o, .local_ready_o);
`default_nettype wire
